// ==== tpg_defines.vh ====
// register offsets, field positions, reset values and timing counts for the pwm timer
`ifndef TPG_DEFINES_VH
`define TPG_DEFINES_VH

// word byte addresses on the wishbone bus
`define TPG_ADDR_CTRL     8'h00
`define TPG_ADDR_CNT      8'h04
`define TPG_ADDR_MOD      8'h08
`define TPG_ADDR_CSC0     8'h0c
`define TPG_ADDR_CMP0     8'h10
`define TPG_ADDR_CSC1     8'h14
`define TPG_ADDR_CMP1     8'h18
`define TPG_ADDR_PWR      8'h1c

// timer control status fields
`define TPG_CTRL_FLAG     7
`define TPG_CTRL_IE       6
`define TPG_CTRL_HALT     5
`define TPG_CTRL_RST      4
`define TPG_CTRL_PRE_HI   2
`define TPG_CTRL_PRE_LO   0

// channel control status fields
`define TPG_CSC_FLAG      7
`define TPG_CSC_IE        6
`define TPG_CSC_MSB       5
`define TPG_CSC_MSA       4
`define TPG_CSC_ELSB      3
`define TPG_CSC_ELSA      2
`define TPG_CSC_TOV       1
`define TPG_CSC_MAX       0

// power mode register fields
`define TPG_PWR_WAIT      0
`define TPG_PWR_STOP      1

// reset values
`define TPG_RST_MOD       16'hffff
`define TPG_RST_CSC       8'h00
`define TPG_RST_CMP       16'h0000

// prescale codes 000..110 give /1../64
`define TPG_PRE_MAX       3'h6
`define TPG_PRE_BITS      6

`endif

// ==== tpg_load_model.sv ====
// pwm load model: measures period and high time on a channel pin
`timescale 1ns/10ps
module tpg_load_model (
    // clock
    input  wire        clk,
    // pwm level seen by the load
    input  wire        pin,
    // latest period, high time and count of periods seen
    output reg  [31:0] per,
    output reg  [31:0] hi,
    output reg  [31:0] npr
);
    reg [31:0] run_q;
    reg [31:0] hic_q;
    reg        last_q;

    initial {per, hi, npr, run_q, hic_q, last_q} = 0;

    // a period runs rise to rise; the first one after a setup is junk
    always @(posedge clk) begin
        run_q <= run_q + 1;
        hic_q <= hic_q + pin;
        last_q <= pin;
        if (pin && !last_q) begin
            per <= run_q;
            hi <= hic_q;
            npr <= npr + 1;
            run_q <= 1;
            hic_q <= 1;
        end
    end
endmodule

// ==== tpg_pwm_timer.v ====
// two-channel 16-bit pwm timer with classic wishbone register access
`timescale 1ns/10ps
`include "tpg_defines.vh"

module tpg_pwm_timer #(
    parameter CW = 16
) (
    // clock and reset
    input  wire          clk,
    input  wire          nrst,
    // wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [7:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output reg  [31:0]   wb_dat_o,
    output reg           wb_ack_o,
    // interrupt request towards the cpu and wakeup
    output wire          timer_irq,
    output wire          wake_req,
    // channel pins; chan1 is a plain gpio when linked
    output reg           chan0_pin,
    output wire          chan1_pin,
    output wire          chan1_pin_oe,
    input  wire          chan1_gpio_out,
    input  wire          chan1_gpio_oe
);

    // software registers
    reg [CW-1:0] cnt_q;
    reg [CW-1:0] period_modulo_q;
    reg [CW-1:0] cmp0_q;
    reg [CW-1:0] cmp1_q;
    reg [7:0]    csc0_q;
    reg [7:0]    csc1_q;
    reg          overflow_flag_q;
    reg          overflow_irq_enable_q;
    reg          counter_halt_q;
    reg [2:0]    prescale_select_q;
    reg          ovf_armed_q;       // flag was read while set
    reg          wait_mode_q;
    reg          stop_mode_q;
    reg [5:0]    pre_q;
    reg          ch1_pin_q;
    reg          active1_q;         // buffered: channel 1 governs width
    reg          written1_q;        // buffered: last compare write was ch1
    reg [1:0]    ch_flag_q;

    // wishbone decode
    wire         req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire         bus_ok   = ~wait_mode_q & ~stop_mode_q;
    wire         wr       = req & wb_we_i & wb_sel_i[0];
    wire         rd       = req & ~wb_we_i;
    wire         linked   = csc0_q[`TPG_CSC_MSB];

    // write strobe for one register; every register write is gated by the low byte lane alone
    function sel_hit;
        input [7:0] a;
        input [7:0] want;
        begin
            sel_hit = (a == want);
        end
    endfunction

    wire w_ctrl = wr & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CTRL);
    wire w_mod  = wr & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_MOD);
    wire w_csc0 = wr & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CSC0);
    wire w_cmp0 = wr & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CMP0);
    wire w_csc1 = wr & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CSC1);
    wire w_cmp1 = wr & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CMP1);
    wire w_pwr  = wr & sel_hit(wb_adr_i, `TPG_ADDR_PWR);
    wire r_ctrl = rd & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CTRL);
    wire r_csc0 = rd & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CSC0);
    wire r_csc1 = rd & bus_ok & sel_hit(wb_adr_i, `TPG_ADDR_CSC1);
    wire trst   = w_ctrl & wb_dat_i[`TPG_CTRL_RST];

    // prescaler tick: divide by 2^ps; stop mode or halt freezes everything
    wire         run      = ~counter_halt_q & ~stop_mode_q;
    wire [6:0]   pre_mask = (7'h01 << prescale_select_q) - 7'h01;
    wire         tick     = run & ((pre_q & pre_mask[5:0]) == pre_mask[5:0]);

    // overflow and compare events, sampled only on ticks
    wire         at_mod   = tick & (cnt_q == period_modulo_q);
    // match on the tick that moves the counter onto the compare value, so the
    // pulse spans exactly compare ticks after overflow: 128 of 256 is half duty
    wire [CW-1:0] cnt_nxt = at_mod ? {CW{1'b0}} : cnt_q + {{(CW-1){1'b0}}, 1'b1};
    wire [CW-1:0] cmp_act = (linked & active1_q) ? cmp1_q : cmp0_q;
    wire         m0       = tick & (cnt_nxt == cmp_act);
    wire         m1       = tick & ~linked & (cnt_nxt == cmp1_q);

    // prescaler and counter; trst clears both without touching registers
    always @(posedge clk) begin
        if (!nrst) begin
            pre_q <= 6'h00;
            cnt_q <= {CW{1'b0}};
        end else if (trst) begin
            pre_q <= 6'h00;
            cnt_q <= {CW{1'b0}};
        end else if (run) begin
            pre_q <= tick ? 6'h00 : pre_q + 6'h01;
            if (at_mod)
                cnt_q <= {CW{1'b0}};
            else if (tick)
                cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // next pin level: overflow toggle, then compare forces, max overrides
    function pin_next;
        input       cur;
        input [7:0] csc;
        input       ovf;
        input       match;
        reg         v;
        begin
            v = cur;
            if (ovf & csc[`TPG_CSC_TOV])
                v = ~v;
            if (match & csc[`TPG_CSC_ELSB])
                v = csc[`TPG_CSC_ELSA];
            if (csc[`TPG_CSC_MAX] & csc[`TPG_CSC_TOV] & (ovf | match))
                v = ~csc[`TPG_CSC_ELSA];
            pin_next = v;
        end
    endfunction

    // pins: compare output whenever elsb is set, whatever msa holds; csc0 msb hands chan1 to the gpio inputs
    always @(posedge clk) begin
        if (!nrst) begin
            chan0_pin <= 1'b0;
            ch1_pin_q <= 1'b0;
        end else begin
            chan0_pin <= pin_next(chan0_pin, csc0_q, at_mod, m0);
            ch1_pin_q <= pin_next(ch1_pin_q, csc1_q, at_mod & ~linked, m1);
        end
    end
    assign chan1_pin    = linked ? chan1_gpio_out : ch1_pin_q;
    assign chan1_pin_oe = linked ? chan1_gpio_oe : 1'b1;

    // buffered channel selection swaps only at overflow
    always @(posedge clk) begin
        if (!nrst) begin
            active1_q  <= 1'b0;
            written1_q <= 1'b0;
        end else if (!linked) begin
            active1_q  <= 1'b0;
            written1_q <= 1'b0;
        end else begin
            if (w_cmp1)
                written1_q <= 1'b1;
            else if (w_cmp0)
                written1_q <= 1'b0;
            if (at_mod)
                active1_q <= w_cmp1 | (written1_q & ~w_cmp0);
        end
    end

    // control and compare registers; compare values live at once
    always @(posedge clk) begin
        if (!nrst) begin
            period_modulo_q       <= `TPG_RST_MOD;
            cmp0_q                <= `TPG_RST_CMP;
            cmp1_q                <= `TPG_RST_CMP;
            csc0_q                <= `TPG_RST_CSC;
            csc1_q                <= `TPG_RST_CSC;
            overflow_irq_enable_q <= 1'b0;
            counter_halt_q        <= 1'b1;
            prescale_select_q     <= 3'h0;
            wait_mode_q           <= 1'b0;
            stop_mode_q           <= 1'b0;
        end else begin
            if (w_mod)
                period_modulo_q <= wb_dat_i[CW-1:0];
            if (w_cmp0)
                cmp0_q <= wb_dat_i[CW-1:0];
            if (w_cmp1)
                cmp1_q <= wb_dat_i[CW-1:0];
            if (w_csc0)
                csc0_q[6:0] <= wb_dat_i[6:0];
            if (w_csc1)
                csc1_q[6:0] <= {wb_dat_i[6], 1'b0, wb_dat_i[4:0]};
            if (w_ctrl) begin
                overflow_irq_enable_q <= wb_dat_i[`TPG_CTRL_IE];
                counter_halt_q        <= wb_dat_i[`TPG_CTRL_HALT];
                // code 111 is the external clock, absent here: clamp to /64
                prescale_select_q     <= (wb_dat_i[2:0] > `TPG_PRE_MAX) ? `TPG_PRE_MAX : wb_dat_i[2:0];
            end
            // any interrupt request ends wait mode
            if (w_pwr) begin
                wait_mode_q <= wb_dat_i[`TPG_PWR_WAIT];
                stop_mode_q <= wb_dat_i[`TPG_PWR_STOP];
            end else if (wake_req) begin
                wait_mode_q <= 1'b0;
            end
        end
    end

    // overflow flag: armed by a read while set, cleared by a later 0 write
    always @(posedge clk) begin
        if (!nrst) begin
            overflow_flag_q <= 1'b0;
            ovf_armed_q     <= 1'b0;
        end else if (at_mod) begin
            overflow_flag_q <= 1'b1;
            ovf_armed_q     <= 1'b0;
        end else begin
            if (r_ctrl & overflow_flag_q)
                ovf_armed_q <= 1'b1;
            if (w_ctrl & ~wb_dat_i[`TPG_CTRL_FLAG] & ovf_armed_q) begin
                overflow_flag_q <= 1'b0;
                ovf_armed_q     <= 1'b0;
            end
        end
    end

    // channel flags with the same two-step clear; a set beats a clear
    wire [1:0] ch_ev   = {m1, m0};
    wire [1:0] ch_rd   = {r_csc1, r_csc0};
    wire [1:0] ch_wz   = {w_csc1 & ~wb_dat_i[`TPG_CSC_FLAG], w_csc0 & ~wb_dat_i[`TPG_CSC_FLAG]};
    reg  [1:0] ch_arm_q;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_chf
            always @(posedge clk) begin
                if (!nrst) begin
                    ch_flag_q[gi] <= 1'b0;
                    ch_arm_q[gi]  <= 1'b0;
                end else if (ch_ev[gi]) begin
                    ch_flag_q[gi] <= 1'b1;
                    ch_arm_q[gi]  <= 1'b0;
                end else begin
                    if (ch_rd[gi] & ch_flag_q[gi])
                        ch_arm_q[gi] <= 1'b1;
                    if (ch_wz[gi] & ch_arm_q[gi]) begin
                        ch_flag_q[gi] <= 1'b0;
                        ch_arm_q[gi]  <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // interrupt request and wakeup
    assign timer_irq = (overflow_flag_q & overflow_irq_enable_q)
                     | (ch_flag_q[0] & csc0_q[`TPG_CSC_IE])
                     | (ch_flag_q[1] & csc1_q[`TPG_CSC_IE] & ~linked);
    assign wake_req  = timer_irq & wait_mode_q;

    // read mux; every register but the power one reads zero while in wait or stop
    reg [31:0] rdata;
    always @* begin
        rdata = 32'h0000_0000;
        case (wb_adr_i)
            `TPG_ADDR_CTRL: rdata[7:0]    = {overflow_flag_q, overflow_irq_enable_q, counter_halt_q,
                                             1'b0, 1'b0, prescale_select_q};
            `TPG_ADDR_CNT:  rdata[CW-1:0] = cnt_q;
            `TPG_ADDR_MOD:  rdata[CW-1:0] = period_modulo_q;
            `TPG_ADDR_CSC0: rdata[7:0]    = {ch_flag_q[0], csc0_q[6:0]};
            `TPG_ADDR_CMP0: rdata[CW-1:0] = cmp0_q;
            `TPG_ADDR_CSC1: rdata[7:0]    = {ch_flag_q[1], csc1_q[6:0]};
            `TPG_ADDR_CMP1: rdata[CW-1:0] = cmp1_q;
            `TPG_ADDR_PWR:  rdata[1:0]    = {stop_mode_q, wait_mode_q};
            default:        rdata = 32'h0000_0000;
        endcase
        if (!bus_ok && wb_adr_i != `TPG_ADDR_PWR)
            rdata = 32'h0000_0000;
    end

    // single-cycle ack one edge after the request, dropped the cycle after
    always @(posedge clk) begin
        if (!nrst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rdata : 32'h0000_0000;
        end
    end

endmodule

// ==== tpg_pwm_timer_assertions.sv ====
// bus, reset and pin-sharing checks on the pwm timer ports
`timescale 1ns/10ps
module tpg_pwm_timer_assertions (
    // timer ports except address, select and write data, watched only
    input wire        clk,
    input wire        nrst,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        timer_irq,
    input wire        wake_req,
    input wire        chan0_pin,
    input wire        chan1_pin,
    input wire        chan1_pin_oe,
    input wire        chan1_gpio_out,
    input wire        chan1_gpio_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_wake_irq: assert property (wake_req |-> timer_irq)
        else $error("wake without interrupt");
    a_gpio_pass: assert property (!chan1_pin_oe |-> chan1_pin == chan1_gpio_out)
        else $error("gpio value not passed");
    a_oe_pass: assert property (!chan1_pin_oe |-> !chan1_gpio_oe)
        else $error("gpio enable not passed");
    a_reset_quiet: assert property ($rose(nrst) |-> !wb_ack_o && !chan0_pin && !timer_irq && chan1_pin_oe)
        else $error("outputs not quiet out of reset");

    c_write: cover property (wb_ack_o && wb_we_i);
    c_pwm: cover property ($rose(chan0_pin));
    c_gpio: cover property (!chan1_pin_oe);
    c_wake: cover property (wake_req);
endmodule

bind tpg_pwm_timer tpg_pwm_timer_assertions u_chk (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_irq(timer_irq), .wake_req(wake_req), .chan0_pin(chan0_pin), .chan1_pin(chan1_pin),
    .chan1_pin_oe(chan1_pin_oe), .chan1_gpio_out(chan1_gpio_out), .chan1_gpio_oe(chan1_gpio_oe));

// ==== tpg_pwm_timer_tb_top.sv ====
// self-checking bench for the two-channel pwm timer
`timescale 1ns/10ps
`include "tpg_defines.vh"
module tpg_pwm_timer_tb_top;
    reg         clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, g_out = 0, g_oe = 0;
    reg  [7:0]  adr = 8'h0;
    reg  [31:0] dat = 32'h0, rdat, rng = 32'h121b7, g_rng = 32'h121b7;
    reg  [15:0] cmp;
    wire [31:0] dat_o, per, hi, npr;
    wire        ack, irq, wake, p0, p1, p1_oe;
    integer     err_count = 0, checked = 0, i, n;

    always #10 clk = ~clk;
    // gpio stimulus keeps changing so a stale pass-through shows
    always @(posedge clk) begin
        g_rng <= xs(g_rng);
        g_oe <= ~g_oe;
        g_out <= g_rng[0];
    end

    tpg_pwm_timer dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .timer_irq(irq), .wake_req(wake), .chan0_pin(p0), .chan1_pin(p1), .chan1_pin_oe(p1_oe),
        .chan1_gpio_out(g_out), .chan1_gpio_oe(g_oe));
    tpg_load_model u_load (.clk(clk), .pin(p0), .per(per), .hi(hi), .npr(npr));

    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // one classic wishbone cycle, entered just after a rising edge
    task bus(input w, input [7:0] a, input [31:0] d);
        begin
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            dat <= d;
            @(posedge clk);
            while (ack !== 1'b1)
                @(posedge clk);
            rdat = dat_o;
            cyc <= 1'b0;
            stb <= 1'b0;
            @(posedge clk);
        end
    endtask

    // halt and clear first, so the new period starts clean
    task setup(input [15:0] m, input [15:0] c, input [7:0] s, input [2:0] ps);
        begin
            bus(1, `TPG_ADDR_CTRL, 32'h30);
            bus(1, `TPG_ADDR_MOD, {16'h0, m});
            bus(1, `TPG_ADDR_CMP0, {16'h0, c});
            bus(1, `TPG_ADDR_CSC0, {24'h0, s});
            bus(1, `TPG_ADDR_CTRL, {29'h0, ps});
        end
    endtask

    // three periods let the output settle after any change
    task meas(input [31:0] ep, input [31:0] eh);
        begin
            n = npr + 3;
            while (npr < n)
                @(posedge clk);
            chk(per, ep);
            chk(hi, eh);
            $display("pwm test end at %0t", $time);
        end
    endtask

    task steady(input e);
        begin
            repeat (300) @(posedge clk);
            n = 0;
            repeat (300) begin
                @(posedge clk);
                if (p0 !== e)
                    n = n + 1;
            end
            chk(n, 0);
            $display("level test end at %0t", $time);
        end
    endtask

    // bounded wait for the interrupt line; running out counts as a mismatch
    task wait_irq;
        begin
            n = 0;
            while (irq !== 1'b1 && n < 600) begin
                @(posedge clk);
                n = n + 1;
            end
            chk(irq, 1'b1);
        end
    endtask

    task complete_run;
        begin
            $display("checks %0d mismatches %0d", checked, err_count);
            if (err_count == 0 && checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    initial begin
        #1000000;
        err_count = err_count + 1;
        complete_run;
    end

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        bus(0, `TPG_ADDR_MOD, 32'h0);
        chk(rdat, 32'hffff);
        bus(0, `TPG_ADDR_CTRL, 32'h0);
        chk(rdat, 32'h20);
        chk(p1_oe, 1'b1);
        setup(16'hff, 16'h80, 8'h1a, 3'h0);
        meas(32'h100, 32'h80);
        bus(1, `TPG_ADDR_CMP0, 32'h40);
        meas(32'h100, 32'h40);
        // lengthen from the overflow interrupt, then shorten from the compare one
        bus(0, `TPG_ADDR_CTRL, 32'h0);
        bus(1, `TPG_ADDR_CTRL, 32'h40);
        wait_irq;
        bus(1, `TPG_ADDR_CMP0, 32'h80);
        meas(32'h100, 32'h80);
        bus(1, `TPG_ADDR_CTRL, 32'h0);
        bus(0, `TPG_ADDR_CSC0, 32'h0);
        bus(1, `TPG_ADDR_CSC0, 32'h5a);
        wait_irq;
        bus(1, `TPG_ADDR_CMP0, 32'h40);
        meas(32'h100, 32'h40);
        for (i = 0; i < 7; i = i + 1) begin
            rng = xs(rng);
            cmp = {13'h0, rng[2:0]} + 16'h1;
            setup(16'hf, cmp, 8'h1a, i[2:0]);
            meas(32'h10 << i, {16'h0, cmp} << i);
        end
        setup(16'hff, 16'h80, 8'h18, 3'h0);
        steady(1'b0);
        setup(16'hff, 16'h80, 8'h1b, 3'h0);
        steady(1'b1);
        bus(1, `TPG_ADDR_CTRL, 32'h20);
        bus(0, `TPG_ADDR_CTRL, 32'h0);
        chk(rdat[7], 1'b1);
        bus(1, `TPG_ADDR_CTRL, 32'h20);
        bus(0, `TPG_ADDR_CTRL, 32'h0);
        chk(rdat[7], 1'b0);
        bus(1, `TPG_ADDR_CTRL, 32'h0);
        bus(1, `TPG_ADDR_PWR, 32'h1);
        bus(0, `TPG_ADDR_MOD, 32'h0);
        chk(rdat, 32'h0);
        bus(1, `TPG_ADDR_PWR, 32'h0);
        // a toggling pin and a running count show whether stop really freezes
        setup(16'hff, 16'h80, 8'h1a, 3'h0);
        bus(0, `TPG_ADDR_CNT, 32'h0);
        cmp = rdat[15:0];
        bus(1, `TPG_ADDR_PWR, 32'h2);
        steady(p0);
        bus(1, `TPG_ADDR_PWR, 32'h0);
        // four ticks up to the stop write, two after the release write
        bus(0, `TPG_ADDR_CNT, 32'h0);
        chk(rdat, {24'h0, cmp[7:0] + 8'h06});
        bus(0, `TPG_ADDR_MOD, 32'h0);
        chk(rdat, 32'hff);
        bus(1, `TPG_ADDR_CTRL, 32'h40);
        wait_irq;
        bus(1, `TPG_ADDR_PWR, 32'h1);
        bus(0, `TPG_ADDR_PWR, 32'h0);
        chk(rdat, 32'h0);
        setup(16'hff, 16'h80, 8'h2a, 3'h0);
        meas(32'h100, 32'h80);
        chk(p1_oe, g_oe);
        bus(1, `TPG_ADDR_CMP1, 32'h40);
        meas(32'h100, 32'h40);
        bus(1, `TPG_ADDR_CMP0, 32'h20);
        meas(32'h100, 32'h20);
        complete_run;
    end
endmodule
